// file: design/rfc_flags_ctrl.sv
// Purpose: flags and control register of the clock, with write/read hold
// Assumes: register port strobes come from the serial command decoder
// Notes:   time bytes are shadows of the running counters
`timescale 1ns/1ps
`include "rfc_regs.svh"

module rfc_flags_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        watchdog_expire,
  input  wire logic        alarm_match,
  input  wire logic        supply_below_threshold,
  input  wire logic        oscillator_fail_detect,
  input  wire logic [55:0] cnt_time,
  output logic      [55:0] cnt_load_time,
  output logic             cnt_load,
  output logic             cal_out_en,
  output logic             rtc_write_allowed,
  output logic             xfer_busy
);

  // one decode used by both the read and write paths
  function automatic logic is_time_addr(input logic [7:0] a);
    return (a >= `RFC_ADDR_TIME_BASE) &&
           (a < (`RFC_ADDR_TIME_BASE + 8'(`RFC_TIME_BYTES)));
  endfunction : is_time_addr

  function automatic rfc_pkg::rfc_idx_t time_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `RFC_ADDR_TIME_BASE;
    return d[`RFC_TIME_IDX_W-1:0];
  endfunction : time_idx

  rfc_xfer_if xf ();

  rfc_xfer_seq u_seq (
    .clk (clk),
    .rst (rst),
    .xf  (xf)
  );

  logic               watchdog_expired_flag_reg;
  logic               watchdog_expired_flag_next;
  logic               alarm_match_flag_reg;
  logic               alarm_match_flag_next;
  logic               supply_fail_flag_reg;
  logic               supply_fail_flag_next;
  logic               oscillator_fail_flag_reg;
  logic               oscillator_fail_flag_next;
  logic               cal_reg;
  logic               cal_next;
  logic               write_hold_reg;
  logic               write_hold_next;
  logic               read_hold_reg;
  logic               read_hold_next;
  logic               time_changed_reg;
  logic               time_changed_next;
  rfc_pkg::rfc_byte_t rdata_reg;
  rfc_pkg::rfc_byte_t rdata_next;
  logic [55:0]        load_time_reg;
  logic [55:0]        load_time_next;
  rfc_pkg::rfc_byte_t shadow_reg  [`RFC_TIME_BYTES];
  rfc_pkg::rfc_byte_t shadow_next [`RFC_TIME_BYTES];

  logic flags_wr;
  logic flags_rd;
  logic time_wr;
  logic hold_release;
  logic shadow_frozen;
  rfc_pkg::rfc_byte_t flags_view;

  assign flags_wr = reg_wr && (reg_addr == `RFC_ADDR_FLAGS);
  assign flags_rd = reg_rd && (reg_addr == `RFC_ADDR_FLAGS);
  assign time_wr  = reg_wr && is_time_addr(reg_addr) && write_hold_reg;
  assign hold_release = flags_wr && write_hold_reg &&
                        !reg_wdata[`RFC_BIT_W];
  // freeze while either hold is set
  // busy also freezes so the edited time is not overwritten mid-copy
  assign shadow_frozen = write_hold_reg || read_hold_reg || xf.busy;

  always_comb begin
    flags_view                 = `RFC_BYTE_ZERO;
    flags_view[`RFC_BIT_WDF]   = watchdog_expired_flag_reg;
    flags_view[`RFC_BIT_AF]    = alarm_match_flag_reg;
    flags_view[`RFC_BIT_PF]    = supply_fail_flag_reg;
    flags_view[`RFC_BIT_OSCILLATOR_FAIL_FLAG]  = oscillator_fail_flag_reg;
    flags_view[`RFC_BIT_ZERO]  = 1'b0;
    flags_view[`RFC_BIT_CAL]   = cal_reg;
    flags_view[`RFC_BIT_W]     = write_hold_reg;
    flags_view[`RFC_BIT_R]     = read_hold_reg;
  end

  // event flags: a set in the read cycle beats the clear
  always_comb begin
    watchdog_expired_flag_next = watchdog_expired_flag_reg;
    alarm_match_flag_next      = alarm_match_flag_reg;
    supply_fail_flag_next      = supply_fail_flag_reg;
    oscillator_fail_flag_next  = oscillator_fail_flag_reg;
    if (flags_rd) begin
      watchdog_expired_flag_next = 1'b0;
      alarm_match_flag_next      = 1'b0;
      supply_fail_flag_next      = 1'b0;
    end
    // oscillator flag cleared by user only
    if (flags_wr && write_hold_reg && !reg_wdata[`RFC_BIT_OSCILLATOR_FAIL_FLAG]) begin
      oscillator_fail_flag_next = 1'b0;
    end
    if (watchdog_expire) begin
      watchdog_expired_flag_next = 1'b1;
    end
    if (alarm_match) begin
      alarm_match_flag_next = 1'b1;
    end
    if (supply_below_threshold) begin
      supply_fail_flag_next = 1'b1;
    end
    if (oscillator_fail_detect) begin
      oscillator_fail_flag_next = 1'b1;
    end
  end

  // control bits are writable at any time so the hold can be entered
  always_comb begin
    cal_next          = cal_reg;
    write_hold_next   = write_hold_reg;
    read_hold_next    = read_hold_reg;
    time_changed_next = time_changed_reg;
    if (flags_wr) begin
      cal_next        = reg_wdata[`RFC_BIT_CAL];
      write_hold_next = reg_wdata[`RFC_BIT_W];
      read_hold_next  = reg_wdata[`RFC_BIT_R];
    end
    if (time_wr) begin
      time_changed_next = 1'b1;
    end
    if (hold_release) begin
      time_changed_next = 1'b0;
    end
  end

  assign xf.start = hold_release && time_changed_reg && !xf.busy;

  always_comb begin
    load_time_next = load_time_reg;
    if (xf.start) begin
      for (int i = 0; i < `RFC_TIME_BYTES; i++) begin
        load_time_next[i*8 +: 8] = shadow_reg[i];
      end
    end
  end

  generate
    for (genvar g = 0; g < `RFC_TIME_BYTES; g++) begin : g_shadow
      always_comb begin
        shadow_next[g] = shadow_reg[g];
        if (time_wr && (time_idx(reg_addr) == rfc_pkg::rfc_idx_t'(g))) begin
          shadow_next[g] = reg_wdata;
        end else if (!shadow_frozen) begin
          shadow_next[g] = cnt_time[g*8 +: 8];
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          shadow_reg[g] <= `RFC_BYTE_ZERO;
        end else begin
          shadow_reg[g] <= shadow_next[g];
        end
      end
    end
  endgenerate

  // read data shows the value before the clear takes effect
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (reg_addr == `RFC_ADDR_FLAGS) begin
        rdata_next = flags_view;
      end else if (is_time_addr(reg_addr)) begin
        rdata_next = shadow_reg[time_idx(reg_addr)];
      end else begin
        rdata_next = `RFC_BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_expired_flag_reg <= 1'b0;
      alarm_match_flag_reg      <= 1'b0;
      supply_fail_flag_reg      <= 1'b0;
      oscillator_fail_flag_reg  <= 1'b0;
      cal_reg                   <= 1'b0;
      write_hold_reg            <= 1'b0;
      read_hold_reg             <= 1'b0;
      time_changed_reg          <= 1'b0;
      rdata_reg                 <= `RFC_FLAGS_RESET;
      load_time_reg             <= '0;
    end else begin
      watchdog_expired_flag_reg <= watchdog_expired_flag_next;
      alarm_match_flag_reg      <= alarm_match_flag_next;
      supply_fail_flag_reg      <= supply_fail_flag_next;
      oscillator_fail_flag_reg  <= oscillator_fail_flag_next;
      cal_reg                   <= cal_next;
      write_hold_reg            <= write_hold_next;
      read_hold_reg             <= read_hold_next;
      time_changed_reg          <= time_changed_next;
      rdata_reg                 <= rdata_next;
      load_time_reg             <= load_time_next;
    end
  end

  assign reg_rdata         = rdata_reg;
  assign cnt_load_time     = load_time_reg;
  // counters load at end of delay
  assign cnt_load          = xf.load;
  assign cal_out_en        = cal_reg;
  assign rtc_write_allowed = write_hold_reg;
  assign xfer_busy         = xf.busy;

endmodule : rfc_flags_ctrl

// file: design/rfc_regs.svh
// Purpose: address map, bit positions and timing counts of the flags block
// Assumes: 50 MHz core clock, byte-wide register port
// Notes:   definitions only
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH

`define RFC_ADDR_FLAGS     8'h00
`define RFC_ADDR_TIME_BASE 8'h09
`define RFC_TIME_BYTES     7
`define RFC_TIME_IDX_W     3

`define RFC_BIT_WDF        7
`define RFC_BIT_AF         6
`define RFC_BIT_PF         5
`define RFC_BIT_OSCILLATOR_FAIL_FLAG       4
`define RFC_BIT_ZERO       3
`define RFC_BIT_CAL        2
`define RFC_BIT_W          1
`define RFC_BIT_R          0

`define RFC_FLAGS_RESET    8'h00
`define RFC_BYTE_ZERO      8'h00

`define RFC_CLK_PERIOD_NS  20
`define RFC_TRANSFER_NS    1000
`define RFC_TRANSFER_CYC   \
  ((`RFC_TRANSFER_NS + `RFC_CLK_PERIOD_NS - 1) / `RFC_CLK_PERIOD_NS)
`define RFC_CNT_W          6

`endif

// file: design/rfc_pkg.sv
// Purpose: shared types of the flags and write control block
// Assumes: nothing beyond the register header
// Notes:   constants live in rfc_regs.svh
`include "rfc_regs.svh"

package rfc_pkg;

  typedef enum logic [1:0] {
    RFC_XF_IDLE = 2'b00,
    RFC_XF_WAIT = 2'b01,
    RFC_XF_LOAD = 2'b10
  } rfc_xf_state_t;

  typedef logic [`RFC_CNT_W-1:0]        rfc_cnt_t;
  typedef logic [7:0]                   rfc_byte_t;
  typedef logic [`RFC_TIME_IDX_W-1:0]   rfc_idx_t;

endpackage : rfc_pkg

// file: design/rfc_xfer_if.sv
// Purpose: handshake between flags block and time transfer sequencer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, load a one-cycle pulse
`timescale 1ns/1ps

interface rfc_xfer_if;
  logic start;
  logic busy;
  logic load;

  modport ctl (output start, input busy, input load);
  modport seq (input start, output busy, output load);
endinterface : rfc_xfer_if

// file: design/rfc_xfer_seq.sv
// Purpose: times the copy of edited time into the timekeeping counters
// Assumes: start only while idle
// Notes:   load pulses once the transfer interval has elapsed
`timescale 1ns/1ps
`include "rfc_regs.svh"

module rfc_xfer_seq (
  input  wire logic clk,
  input  wire logic rst,
  rfc_xfer_if.seq   xf
);

  rfc_pkg::rfc_xf_state_t state_reg;
  rfc_pkg::rfc_xf_state_t state_next;
  rfc_pkg::rfc_cnt_t      cnt_reg;
  rfc_pkg::rfc_cnt_t      cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      rfc_pkg::RFC_XF_IDLE: begin
        if (xf.start) begin
          state_next = rfc_pkg::RFC_XF_WAIT;
          cnt_next   = `RFC_CNT_W'(`RFC_TRANSFER_CYC - 1);
        end
      end
      rfc_pkg::RFC_XF_WAIT: begin
        if (cnt_reg == '0) begin
          state_next = rfc_pkg::RFC_XF_LOAD;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      rfc_pkg::RFC_XF_LOAD: begin
        state_next = rfc_pkg::RFC_XF_IDLE;
      end
      default: begin
        state_next = rfc_pkg::RFC_XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= rfc_pkg::RFC_XF_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign xf.busy = (state_reg != rfc_pkg::RFC_XF_IDLE);
  assign xf.load = (state_reg == rfc_pkg::RFC_XF_LOAD);

endmodule : rfc_xfer_seq

// file: verif/rfc_flags_ctrl_props.sv
// Purpose: port checker of the flags block
// Assumes: one clock, synchronous reset
// Notes:   bound below the module
`timescale 1ns/1ps
module rfc_flags_ctrl_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       alarm_match,
  input wire logic       supply_below_threshold,
  input wire logic       cnt_load,
  input wire logic       rtc_write_allowed,
  input wire logic       xfer_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire at_f = reg_addr == 8'h00;
  wire rd_f = reg_rd && at_f;
  wire rd_t = reg_rd && reg_addr == 8'h09;
  wire wr_t = reg_wr && reg_addr == 8'h09;
  AST_W_RESET: assert property ($fell(rst) |-> !rtc_write_allowed)
    else $error("hold set after reset");
  AST_W_SET: assert property (reg_wr && at_f
    |=> rtc_write_allowed == $past(reg_wdata[1]))
    else $error("hold bit not taken");
  AST_PF: assert property (supply_below_threshold
    ##1 supply_below_threshold && rd_f |=> reg_rdata[5])
    else $error("supply flag missing");
  AST_CLR: assert property (rd_f && !alarm_match ##1 rd_f
    |=> !reg_rdata[6])
    else $error("alarm flag kept");
  AST_OSC: assert property (rd_f ##1 rd_f
    |=> reg_rdata[4] || !$past(reg_rdata[4]))
    else $error("oscillator flag lost");
  AST_FREEZE: assert property (rtc_write_allowed && rd_t
    ##1 rtc_write_allowed && rd_t |=> $stable(reg_rdata))
    else $error("time moved while held");
  AST_TWR: assert property (rtc_write_allowed && wr_t ##1 rd_t
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("time write lost");
  AST_XF_GO: assert property ($rose(xfer_busy)
    |-> $past(reg_wr) && $past(at_f) && !$past(reg_wdata[1]))
    else $error("transfer without release");
  AST_XF_TIME: assert property ($rose(xfer_busy)
    |-> !cnt_load [*8] ##43 cnt_load ##1 !xfer_busy)
    else $error("load at wrong time");
endmodule : rfc_flags_ctrl_props

bind rfc_flags_ctrl rfc_flags_ctrl_props i_rfc_flags_ctrl_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .alarm_match(alarm_match), .cnt_load(cnt_load),
  .supply_below_threshold(supply_below_threshold),
  .rtc_write_allowed(rtc_write_allowed), .xfer_busy(xfer_busy));

// file: verif/rfc_host_model.sv
// Purpose: serial host stand-in on the register port
// Assumes: strobes change only at rising edges
// Notes:   released lines show inverted junk
`timescale 1ns/1ps
module rfc_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // one write or read access, one rising edge waited in the task
  task automatic go(input logic w, input logic [7:0] a, d);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask : go
  // idle lines must not look valid
  task automatic idle(input int n);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
    repeat (n) @(posedge clk);
  endtask : idle
endmodule : rfc_host_model

// file: verif/test_rfc_flags_ctrl.sv
// Purpose: self-checking bench of the flags block
// Assumes: counters modelled here, host model on the port
// Notes:   run ends in conclude
`timescale 1ns/1ps
module test_rfc_flags_ctrl;
  logic        clk, rst, reg_wr, reg_rd, cnt_load, cal_out_en;
  logic        watchdog_expire, alarm_match, oscillator_fail_detect;
  logic        supply_below_threshold, rtc_write_allowed, xfer_busy;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [55:0] cnt_time, cnt_load_time;
  int          fails, n_compared, cyc;
  rfc_host_model i_rfc_host_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  rfc_flags_ctrl i_rfc_flags_ctrl (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .watchdog_expire(watchdog_expire), .alarm_match(alarm_match),
    .supply_below_threshold(supply_below_threshold),
    .oscillator_fail_detect(oscillator_fail_detect),
    .cnt_time(cnt_time), .cnt_load_time(cnt_load_time),
    .cnt_load(cnt_load), .cal_out_en(cal_out_en),
    .rtc_write_allowed(rtc_write_allowed), .xfer_busy(xfer_busy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // counters take the edited time on load
  // reset clears the model so no unknown leaks into the shadow checks
  always @(posedge clk) begin
    if (rst)
      cnt_time <= 56'h0;
    else
      cnt_time <= cnt_load ? cnt_load_time : cnt_time + 56'h1;
    cyc      <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      conclude;
    end
  end
  task automatic conclude;
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e || $isunknown(g)) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    i_rfc_host_model.go(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_rfc_host_model.go(1'b0, a, 8'h00);
  endtask : rd
  task automatic gap(input int n);
    i_rfc_host_model.idle(n);
  endtask : gap
  task automatic rchk(input string nm, input logic [7:0] a, e);
    rd(a);
    gap(1);
    chk(nm, e, reg_rdata);
  endtask : rchk
  task automatic t_reset;
    rchk("flags", 8'h00, 8'h00);
    chk("hold", 8'h00, {7'h00, rtc_write_allowed});
  endtask : t_reset
  task automatic t_events;
    {watchdog_expire, alarm_match, oscillator_fail_detect} <= 3'h7;
    gap(1);
    {watchdog_expire, alarm_match, oscillator_fail_detect} <= 3'h0;
    rd(8'h00);
    rd(8'h00);
    chk("flags", 8'hD0, reg_rdata);
    gap(1);
    chk("flags", 8'h10, reg_rdata);
    supply_below_threshold <= 1'b1;
    gap(1);
    rd(8'h00);
    rd(8'h00);
    chk("supply", 8'h30, reg_rdata);
    gap(1);
    chk("supply", 8'h30, reg_rdata);
    supply_below_threshold <= 1'b0;
    gap(1);
    rchk("supply", 8'h00, 8'h30);
    rchk("supply", 8'h00, 8'h10);
  endtask : t_events
  task automatic t_ctrl;
    wr(8'h00, 8'h02);
    wr(8'h00, 8'h02);
    chk("hold", 8'h01, {7'h00, rtc_write_allowed});
    wr(8'h00, 8'h04);
    gap(1);
    chk("cal", 8'h01, {7'h00, cal_out_en});
    rchk("flags", 8'h00, 8'h04);
    chk("busy", 8'h00, {7'h00, xfer_busy});
  endtask : t_ctrl
  task automatic t_edit;
    logic [7:0] q0;
    logic [7:0] q1;
    int         n;
    wr(8'h00, 8'h02);
    q0 = cnt_time[7:0];
    q1 = cnt_time[15:8];
    rd(8'h09);
    rd(8'h09);
    chk("frozen", q0, reg_rdata);
    gap(1);
    chk("frozen", q0, reg_rdata);
    wr(8'h09, 8'h5A);
    rd(8'h09);
    gap(1);
    chk("time", 8'h5A, reg_rdata);
    wr(8'h00, 8'h00);
    gap(1);
    n = 1;
    while (cnt_load !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("delay", 8'h33, n[7:0]);
    chk("load", 8'h5A, cnt_load_time[7:0]);
    chk("load", q1, cnt_load_time[15:8]);
    gap(3);
    q0 = cnt_time[7:0];
    rchk("tracking", 8'h09, q0);
  endtask : t_edit
  task automatic t_rhold;
    logic [7:0] q0;
    wr(8'h00, 8'h01);
    q0 = cnt_time[7:0];
    gap(2);
    rchk("rhold", 8'h09, q0);
    wr(8'h09, 8'hA5);
    rchk("refused", 8'h09, q0);
    rchk("unmapped", 8'h20, 8'h00);
    wr(8'h00, 8'h00);
    gap(1);
    chk("busy", 8'h00, {7'h00, xfer_busy});
  endtask : t_rhold
  initial begin
    {rst, watchdog_expire, alarm_match} = 3'h4;
    {supply_below_threshold, oscillator_fail_detect} = 2'h0;
    fails      = 0;
    n_compared = 0;
    cyc        = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_events;
    t_ctrl;
    t_edit;
    t_rhold;
    conclude;
  end
endmodule : test_rfc_flags_ctrl
